// ==== bench/counter_array_chk.sv ====
// Concurrent checks on the counter_array ports.
// Assumes it is bound to counter_array; one clock domain.
`timescale 1ns/100ps

module counter_array_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave side
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [counter_array_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Counter status
    input wire logic [counter_array_pkg::COUNT_W-1:0] count_value,
    input wire logic count_tick,
    input wire logic intermediate_overflow,
    input wire logic watchdog_duty,
    input wire logic irq
);
    import counter_array_pkg::*;

    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic take;
    logic rd_low;
    logic rd_high;
    logic wr_cnt;
    logic [7:0] snap_q;

    // Bus decode; a strobe held through ack is taken again
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd_low = take && !wb_we_i && wb_adr_i == ADDR_COUNT_LOW;
    assign rd_high = take && !wb_we_i && wb_adr_i == ADDR_COUNT_HIGH;
    assign wr_cnt = take && wb_we_i && (wb_adr_i == ADDR_COUNT_LOW ||
        wb_adr_i == ADDR_COUNT_HIGH);

    // Own copy of the high byte frozen by each low byte read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            snap_q <= 8'h00;
        end else if (rd_low) begin
            snap_q <= count_value[15:8];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("no ack one cycle after a request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    reset_state_a: assert property ($rose(rst_n) |-> watchdog_duty &&
        !irq && !wb_ack_o && count_value == COUNT_RESET)
        else $error("wrong state after reset");
    low_read_a: assert property (wb_ack_o && $past(rd_low) |->
        wb_dat_o == {24'h0, $past(count_value[7:0])})
        else $error("low byte read wrong");
    shadow_read_a: assert property (wb_ack_o && $past(rd_high) |->
        wb_dat_o == {24'h0, snap_q})
        else $error("high byte read not from snapshot");
    wdog_lock_a: assert property (watchdog_duty && wr_cnt |=>
        count_value == $past(count_value) ||
        count_value == $past(count_value) + 16'h0001)
        else $error("count written in watchdog duty");
    count_step_a: assert property ($changed(count_value) &&
        !$past(wb_cyc_i && wb_stb_i && wb_we_i) |->
        count_value == $past(count_value) + 16'h0001)
        else $error("count moved by other than one");
    tick_step_a: assert property (!$past(wb_cyc_i && wb_stb_i &&
        wb_we_i) |-> count_value == $past(count_value) + 16'(count_tick))
        else $error("count differs from tick pulses");
    inter_wrap_a: assert property (intermediate_overflow |->
        count_value[7:0] == 8'h00 || $past(count_value[7:0]) == 8'h00)
        else $error("intermediate overflow without carry");

    // Main scenarios reached
    wrap_c: cover property (count_value == COUNT_RESET &&
        $past(count_value) == COUNT_ALL_ONES);
    shadow_c: cover property (wb_ack_o && $past(rd_high));
    irq_c: cover property ($rose(irq));
endmodule

// ==== bench/counter_array_tb.sv ====
// Self-checking bench for counter_array and the interrupt model.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/100ps
`define CHECK(nm, exp, got) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("ERROR %s exp %0h got %0h", nm, exp, got); \
        end \
    end

module counter_array_tb;
    import counter_array_pkg::*;
    // Bench signals, all inputs quiet at time zero
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic t0 = 1'b0;
    logic ext_in = 1'b0;
    logic xosc = 1'b0;
    logic lfosc = 1'b0;
    logic idle = 1'b0;
    logic [2:0] chev = 3'b000;
    logic gie = 1'b0;
    logic aie = 1'b0;
    logic [31:0] rdat;
    logic ack;
    logic wdog;
    logic irq;
    logic taken;
    logic [31:0] rd;
    int num_errors = 0;
    int samples_checked = 0;

    always #2.5 ref_clk = ~ref_clk;

    counter_array i_counter_array (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .timer0_overflow(t0),
        .external_count_input(ext_in), .ext_osc_clk(xosc),
        .lf_osc_clk(lfosc), .cpu_idle(idle), .channel_event(chev),
        .count_value(), .count_tick(), .intermediate_overflow(),
        .watchdog_duty(wdog), .irq(irq)
    );
    irq_ctrl_model i_irq_ctrl_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .irq(irq),
        .global_irq_enable(gie), .array_irq_enable(aie),
        .irq_taken(taken)
    );

    task automatic give_verdict();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Classic single cycle; ev pulses channel events at the take edge
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [7:0] d, input logic [2:0] ev = 3'b000);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        chev <= ev;
        @(posedge ref_clk);
        chev <= 3'b000;
        while (ack !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 100) begin
            num_errors++;
            give_verdict();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Reset values, then watchdog duty locks the counter and every mode bit but the duty bit
    task automatic t_reset();
        `CHECK("wdog", 1'b1, wdog)
        bus(1'b0, ADDR_MODE, 8'h00);
        `CHECK("mode", {24'h0, MODE_RESET}, rd)
        bus(1'b0, ADDR_IRQ_MASK, 8'h00);
        `CHECK("mask", {27'h0, MASK_RESET}, rd)
        bus(1'b1, ADDR_COUNT_LOW, 8'h55);
        bus(1'b0, ADDR_COUNT_LOW, 8'h00);
        `CHECK("locked low", 32'h0, rd)
        bus(1'b1, ADDR_MODE, 8'h09);
        bus(1'b0, ADDR_MODE, 8'h00);
        `CHECK("locked mode", 32'h0, rd)
        `CHECK("wdog off", 1'b0, wdog)
        bus(1'b0, 8'h3c, 8'h00);
        `CHECK("unmapped", 32'h0, rd)
    endtask

    // Wrap from all ones with the enable off, then on, then both clears
    task automatic t_overflow();
        bus(1'b1, ADDR_COUNT_LOW, 8'hfe);
        bus(1'b1, ADDR_COUNT_HIGH, 8'hff);
        bus(1'b1, ADDR_MODE, 8'h09);
        bus(1'b1, ADDR_MODE, 8'h00);
        bus(1'b0, ADDR_FLAGS, 8'h00);
        `CHECK("wrap flags", 32'h3, rd)
        `CHECK("masked irq", 1'b0, irq)
        bus(1'b1, ADDR_IRQ_MASK, 8'h01);
        gie <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHECK("irq", 1'b1, irq)
        `CHECK("one enable", 1'b0, taken)
        aie <= 1'b1;
        repeat (20) @(posedge ref_clk);
        `CHECK("taken", 1'b1, taken)
        bus(1'b0, ADDR_FLAGS, 8'h00);
        `CHECK("flag kept", 32'h3, rd)
        bus(1'b1, ADDR_FLAGS, 8'h1e);
        bus(1'b0, ADDR_FLAGS, 8'h00);
        `CHECK("zero clear", 32'h2, rd)
        `CHECK("irq off", 1'b0, irq)
        bus(1'b1, ADDR_IRQ_STATUS, 8'h02);
        bus(1'b0, ADDR_FLAGS, 8'h00);
        `CHECK("one clear", 32'h0, rd)
        bus(1'b1, ADDR_COUNT_HIGH, 8'h06);
        for (int c = 0; c < 2; c++) begin
            bus(1'b1, ADDR_COUNT_LOW, 8'hfe);
            bus(1'b1, ADDR_MODE, 8'h39);
            bus(1'b1, ADDR_MODE, 8'h00);
            bus(1'b0, ADDR_FLAGS, 8'h00);
            `CHECK("bit 11 carry", {30'h0, c[0], 1'b0}, rd)
        end
    endtask

    // High byte read long after the low byte still shows the snapshot
    task automatic t_shadow();
        bus(1'b1, ADDR_COUNT_LOW, 8'hf0);
        bus(1'b1, ADDR_COUNT_HIGH, 8'h12);
        bus(1'b1, ADDR_MODE, 8'h09);
        bus(1'b0, ADDR_COUNT_LOW, 8'h00);
        repeat (40) @(posedge ref_clk);
        bus(1'b0, ADDR_COUNT_HIGH, 8'h00);
        `CHECK("snapshot", 32'h12, rd)
        bus(1'b1, ADDR_MODE, 8'h00);
        bus(1'b0, ADDR_COUNT_LOW, 8'h00);
        `CHECK("no lost tick", 1'b1, rd[7:0] inside {[8'h20:8'h22]})
    endtask

    // Every select code with all sources active; idle throughout,
    // only the last row suspends
    task automatic t_timebase();
        int lo[9] = '{8, 24, 12, 6, 97, 3, 2, 0, 0};
        int hi[9] = '{9, 25, 12, 6, 99, 3, 2, 0, 0};
        logic [2:0] sel;
        logic [15:0] full;
        idle <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            sel = (i == 8) ? 3'd4 : 3'(i);
            bus(1'b1, ADDR_COUNT_LOW, 8'h00);
            bus(1'b1, ADDR_COUNT_HIGH, 8'h00);
            bus(1'b1, ADDR_MODE, {i == 8, 3'b000, sel, 1'b1});
            for (int k = 0; k < 96; k++) begin
                t0 <= (k % 8 == 0);
                ext_in <= ~k[3]; // Slow falling edges
                xosc <= ~k[1];
                lfosc <= (k % 6 < 3);
                @(posedge ref_clk);
            end
            bus(1'b1, ADDR_MODE, 8'h00);
            bus(1'b0, ADDR_COUNT_LOW, 8'h00);
            full[7:0] = rd[7:0];
            bus(1'b0, ADDR_COUNT_HIGH, 8'h00);
            full[15:8] = rd[7:0];
            `CHECK("ticks", 1'b1, full inside {[lo[i]:hi[i]]})
        end
        idle <= 1'b0;
    endtask

    // Channel flags, per channel mask, clear and same-cycle set
    task automatic t_channels();
        logic [4:0] exp;
        exp = 5'h1c;
        bus(1'b1, ADDR_FLAGS, 8'h00);
        chev <= 3'b111;
        @(posedge ref_clk);
        chev <= 3'b000;
        bus(1'b0, ADDR_FLAGS, 8'h00);
        `CHECK("chan flags", 32'h1c, rd)
        `CHECK("chan masked", 1'b0, irq)
        for (int n = 0; n < 3; n++) begin
            bus(1'b1, ADDR_IRQ_MASK, 8'h04 << n);
            repeat (2) @(posedge ref_clk);
            `CHECK("chan irq", 1'b1, irq)
            bus(1'b1, ADDR_IRQ_STATUS, 8'h04 << n);
            exp = exp & ~(5'h04 << n);
            bus(1'b0, ADDR_FLAGS, 8'h00);
            `CHECK("chan left", {27'h0, exp}, rd)
            `CHECK("chan irq off", 1'b0, irq)
        end
        bus(1'b1, ADDR_FLAGS, 8'h00, 3'b010);
        bus(1'b0, ADDR_FLAGS, 8'h00);
        `CHECK("set wins", 32'h08, rd)
    endtask

    initial begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_overflow();
        t_shadow();
        t_timebase();
        t_channels();
        give_verdict();
    end

    // Watchdog well beyond the little over a thousand cycles the run needs
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
endmodule

bind counter_array counter_array_chk i_counter_array_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_value(count_value),
    .count_tick(count_tick),
    .intermediate_overflow(intermediate_overflow),
    .watchdog_duty(watchdog_duty), .irq(irq)
);

// ==== bench/irq_ctrl_model.sv ====
// Interrupt acceptance of the processor as seen from the array.
// Assumes irq is a level from counter_array on ref_clk.
`timescale 1ns/100ps

module irq_ctrl_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Request and the two processor enables
    input wire logic irq,
    input wire logic global_irq_enable,
    input wire logic array_irq_enable,
    // Request accepted by the core
    output logic irq_taken
);
    // Both enables gate the request; vectoring never touches the
    // flags, so software has to clear them itself
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_taken <= 1'b0;
        end else begin
            irq_taken <= irq && global_irq_enable && array_irq_enable;
        end
    end
endmodule

// ==== rtl/counter_array.sv ====
// Shared 16-bit counter of the counter array with timebase selection,
// overflow flags, coherent byte reads and interrupt merging.
// Assumes a classic Wishbone master and capture/compare channels that
// report their events as one-cycle pulses on ref_clk.
`timescale 1ns/100ps

module counter_array (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [counter_array_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Timebase sources
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_clk,
    input wire logic lf_osc_clk,
    // Processor state
    input wire logic cpu_idle,
    // Channel events from the capture/compare modules
    input wire logic [2:0] channel_event,
    // Status toward the channels and the interrupt controller
    output logic [counter_array_pkg::COUNT_W-1:0] count_value,
    output logic count_tick,
    output logic intermediate_overflow,
    output logic watchdog_duty,
    output logic irq
);
    import counter_array_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] count_d;
    logic [BYTE_W-1:0] shadow_q;
    mode_s mode_q;
    mode_s mode_d;
    flags_s flags_q;
    flags_s flags_d;
    flags_s mask_q;
    logic [3:0] prescale_q;
    logic tick_q;
    logic inter_q;
    logic irq_q;
    logic ack_q;
    logic [31:0] rdata_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic access;
    logic wr;
    logic rd;
    logic wr_low;
    logic wr_high;
    logic wr_mode;
    logic wr_flags;
    logic wr_mask;
    logic wr_status;
    logic rd_low;

    // One access per request; ack_q blocks a second take
    assign access = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = access & wb_we_i;
    assign rd = access & ~wb_we_i;
    assign wr_low = wr & wb_sel_i[0] & (wb_adr_i == ADDR_COUNT_LOW);
    assign wr_high = wr & wb_sel_i[0] & (wb_adr_i == ADDR_COUNT_HIGH);
    assign wr_mode = wr & wb_sel_i[0] & (wb_adr_i == ADDR_MODE);
    assign wr_flags = wr & wb_sel_i[0] & (wb_adr_i == ADDR_FLAGS);
    assign wr_mask = wr & wb_sel_i[0] & (wb_adr_i == ADDR_IRQ_MASK);
    assign wr_status = wr & wb_sel_i[0] & (wb_adr_i == ADDR_IRQ_STATUS);
    assign rd_low = rd & (wb_adr_i == ADDR_COUNT_LOW);

    // ------------------------------------------------------------
    // Synchronised outside sources
    // ------------------------------------------------------------
    logic [SRC_N-1:0] src_edge;
    logic [SRC_N-1:0] src_div_tick;
    logic [SRC_N-1:0] src_async;

    assign src_async[SRC_EXT_INPUT] = external_count_input;
    assign src_async[SRC_EXT_OSC] = ext_osc_clk;
    assign src_async[SRC_LF_OSC] = lf_osc_clk;

    // The external input counts falling edges, the oscillators count
    // rising edges and are then divided by eight
    for (genvar i = 0; i < SRC_N; i++) begin : g_src
        logic [2:0] div_q;

        edge_sync #(
            .FALLING(i == SRC_EXT_INPUT)
        ) u_sync (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .async_in(src_async[i]),
            .edge_pulse(src_edge[i])
        );

        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                div_q <= '0;
            end else if (src_edge[i]) begin
                div_q <= div_q + 3'h1;
            end
        end

        assign src_div_tick[i] = src_edge[i] & (div_q == OSC_DIV_LAST);
    end

    // ------------------------------------------------------------
    // System clock prescaler
    // ------------------------------------------------------------
    // Free running mod twelve; the divide-by-four tap reuses it since
    // twelve is a multiple of four, which saves a second counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_q <= '0;
        end else if (prescale_q == PRESCALE_LAST) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Timebase select
    // ------------------------------------------------------------
    logic tb_tick;
    logic count_en;
    logic tick;

    always_comb begin
        tb_tick = 1'b0;
        unique case (mode_q.timebase_select)
            TB_DIV12: tb_tick = (prescale_q == PRESCALE_LAST);
            TB_DIV4: tb_tick = (prescale_q[1:0] == DIV4_PHASE);
            TB_TIMER0: tb_tick = timer0_overflow;
            TB_EXT_FALL: tb_tick = src_edge[SRC_EXT_INPUT];
            TB_SYSCLK: tb_tick = 1'b1;
            TB_EXT_OSC: tb_tick = src_div_tick[SRC_EXT_OSC];
            TB_LF_OSC: tb_tick = src_div_tick[SRC_LF_OSC];
            TB_RESERVED: tb_tick = 1'b0;
        endcase
    end

    // Idle only stops counting when software asks for it
    assign count_en = mode_q.run & ~(mode_q.idle_suspend_bit & cpu_idle);
    assign tick = tb_tick & count_en;

    // ------------------------------------------------------------
    // Overflow detection
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] inter_mask;
    logic main_wrap;
    logic inter_carry;

    // Low bits below the chosen carry position, eight to eleven wide
    assign inter_mask = COUNT_W'((32'(INTER_BASE_MASK) << mode_q.cycle_length)
                                 | 32'(INTER_BASE_MASK));
    assign main_wrap = tick & (count_q == COUNT_ALL_ONES);
    assign inter_carry = tick & ((count_q & inter_mask) == inter_mask);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // A byte write replaces that byte; the other byte still takes the
    // tick so software never loses a count it did not overwrite
    always_comb begin
        count_d = count_q + COUNT_W'(tick);
        if (wr_low && !mode_q.watchdog_duty) begin
            count_d[BYTE_W-1:0] = wb_dat_i[BYTE_W-1:0];
        end
        if (wr_high && !mode_q.watchdog_duty) begin
            count_d[COUNT_W-1:BYTE_W] = wb_dat_i[BYTE_W-1:0];
        end
    end

    // Reads are not in this path at all, so they cannot stall it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Snapshot of the high byte taken by every low byte read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_q <= '0;
        end else if (rd_low) begin
            shadow_q <= count_q[COUNT_W-1:BYTE_W];
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    // Written byte seen as a mode word
    mode_s mode_wr;
    assign mode_wr = mode_s'(wb_dat_i[MODE_W-1:0]);

    // During watchdog duty only the duty bit itself may be changed,
    // which keeps a runaway program from retiming the watchdog
    always_comb begin
        mode_d = mode_q;
        if (wr_mode) begin
            if (mode_q.watchdog_duty) begin
                mode_d.watchdog_duty = mode_wr.watchdog_duty;
            end else begin
                mode_d = mode_wr;
            end
        end
    end

    // Reset brings channel 2 up in watchdog duty
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= mode_s'(MODE_RESET);
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    flags_s flag_set;
    flags_s flag_clr;

    // Sets come from hardware alone, never gated by an enable
    always_comb begin
        flag_set = '0;
        flag_set.main_overflow_flag = main_wrap;
        flag_set.intermediate_overflow_flag = inter_carry;
        flag_set.channel_event_flag = channel_event;
    end

    // Flags register clears on a zero; status alias clears on a one
    always_comb begin
        flag_clr = '0;
        if (wr_flags) begin
            flag_clr = flags_s'(~wb_dat_i[FLAG_W-1:0]);
        end else if (wr_status) begin
            flag_clr = flags_s'(wb_dat_i[FLAG_W-1:0]);
        end
    end

    // Set beats clear; nothing else clears a flag
    assign flags_d = (flags_q & ~flag_clr) | flag_set;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q <= flags_s'(FLAGS_RESET);
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask and request
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= flags_s'(MASK_RESET);
        end else if (wr_mask) begin
            mask_q <= flags_s'(wb_dat_i[FLAG_W-1:0]);
        end
    end

    // Registered from the next-state flags so the request rises on the
    // same clock edge as the flag, not one later, and never glitches
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_d & mask_q);
        end
    end

    // ------------------------------------------------------------
    // Status toward the channels
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 1'b0;
            inter_q <= 1'b0;
        end else begin
            tick_q <= tick;
            inter_q <= inter_carry;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Every address answers in one cycle; unmapped ones read zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= access;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (rd) begin
            rdata_q <= '0;
            unique case (wb_adr_i)
                ADDR_COUNT_LOW: rdata_q[BYTE_W-1:0] <= count_q[BYTE_W-1:0];
                ADDR_COUNT_HIGH: rdata_q[BYTE_W-1:0] <= shadow_q;
                ADDR_MODE: rdata_q[MODE_W-1:0] <= mode_q;
                ADDR_FLAGS: rdata_q[FLAG_W-1:0] <= flags_q;
                ADDR_IRQ_MASK: rdata_q[FLAG_W-1:0] <= mask_q;
                ADDR_IRQ_STATUS: rdata_q[FLAG_W-1:0] <= flags_q;
                default: rdata_q <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign count_value = count_q;
    assign count_tick = tick_q;
    assign intermediate_overflow = inter_q;
    assign watchdog_duty = mode_q.watchdog_duty;
    assign irq = irq_q;

endmodule

// ==== rtl/counter_array_pkg.sv ====
// Shared constants and types for the counter array timebase and interrupt
// block. Assumes a 32-bit classic Wishbone slave with byte addressing.
package counter_array_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_LOW = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_COUNT_HIGH = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h14;

    // ----------------------------------------------------------------
    // Field types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TB_DIV12 = 3'b000,
        TB_DIV4 = 3'b001,
        TB_TIMER0 = 3'b010,
        TB_EXT_FALL = 3'b011,
        TB_SYSCLK = 3'b100,
        TB_EXT_OSC = 3'b101,
        TB_LF_OSC = 3'b110,
        TB_RESERVED = 3'b111
    } timebase_e;

    // Array mode register, bit 0 upward: run, timebase, cycle length,
    // watchdog duty of channel 2, idle suspend
    typedef struct packed {
        logic idle_suspend_bit;
        logic watchdog_duty;
        logic [1:0] cycle_length;
        timebase_e timebase_select;
        logic run;
    } mode_s;

    // Event flags; the irq mask uses the same layout
    typedef struct packed {
        logic [2:0] channel_event_flag;
        logic intermediate_overflow_flag;
        logic main_overflow_flag;
    } flags_s;

    localparam int FLAG_W = 5;
    localparam int MODE_W = 8;
    localparam logic [MODE_W-1:0] MODE_RESET = 8'h40;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;
    localparam logic [FLAG_W-1:0] MASK_RESET = 5'h00;

    // ----------------------------------------------------------------
    // Counting constants
    // ----------------------------------------------------------------
    localparam int COUNT_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [COUNT_W-1:0] INTER_BASE_MASK = 16'h00ff;
    localparam logic [3:0] PRESCALE_LAST = 4'hb;
    localparam logic [1:0] DIV4_PHASE = 2'h3;
    localparam logic [2:0] OSC_DIV_LAST = 3'h7;
    localparam int SRC_N = 3;
    localparam int SRC_EXT_INPUT = 0;
    localparam int SRC_EXT_OSC = 1;
    localparam int SRC_LF_OSC = 2;

endpackage

// ==== rtl/edge_sync.sv ====
// Two-stage synchroniser with an edge detector behind it.
// Assumes the input changes no faster than a few reference clocks.
`timescale 1ns/100ps

module edge_sync #(
    parameter bit FALLING = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Asynchronous level in, one-cycle pulse out
    input wire logic async_in,
    output logic edge_pulse
);

    logic meta_q;
    logic sync_q;
    logic last_q;

    // ------------------------------------------------------------
    // Synchroniser; only the second stage looks at the first
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Opposite of the counted edge, so release fakes no edge
            meta_q <= ~FALLING;
            sync_q <= ~FALLING;
            last_q <= ~FALLING;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // Edge seen between the second and third stage
    assign edge_pulse = FALLING ? (last_q & ~sync_q) : (sync_q & ~last_q);

endmodule
